// File: hw/sdc_ctrl.sv
// Purpose: ecc capture, region decode, sdram clocks and power-fail sequencing
// Assumes: memory datapath answers on sys_clk, one read outstanding
// Notes:   power-fail machine keeps running while rst is high
// Function
// (R01) On a read ecc error, capture failing address and log the error details.
// (R02) A captured read error raises a non-maskable interrupt to the core.
// (R03) Reading the interrupt status returns it and clears it; it names the pair.
// (R04) Control bit 0 enables single-bit reporting; scrubbing software clears it.
// (R05) A single-bit error read returns corrected data for read-modify-write scrubbing.
// (R06) Software scrubs only single-bit errors after checking the log.
// (R07) Software re-reads the captured address; a new error counts as multi-bit.
// (R08) Every write XORs the test mask into the generated check bits.
// (R09) Reading data written with a non-zero mask follows the error path.
// (R10) The register window is decoded at fixed bounds regardless of bases.
// (R11) Sdram region comes from base plus two bank boundary values.
// (R12) Each flash region comes from its own base and size.
// (R13) Priority: register window, flash 0, flash 1, then sdram.
// (R14) Four replicated sdram clock outputs are driven.
// (R15) Sdram clock returns on a feedback input clocking the sdram pin logic.
// (R16) Sdram region is limited to 512 Mbytes.
// (R17) Issuing self-refresh drives both clock-enable outputs low.
// (R18) External logic keeps clock enables low while supply decays.
// (R19) Primary reset assertion starts the power-fail state machine.
// (R20) System asserts reset with at least 1 us of good power left.
// (R21) Bus clock runs at least 20 cycles after reset assertion.
// (R22) Ignore bus, wait eight, precharge-all, auto-refresh, wait eight, self-refresh.
// (R23) Any interrupt status bit rising from 0 to 1 raises the interrupt.
// (R24) Power-fail machine is initialised only by the dedicated power-delay input.
// (R25) After power returns, clock enables stay low until mode-register-set.
// (R26) Masked single-bit errors change no capture, log, status or interrupt.
// (R27) A zero test mask leaves generated check bits unchanged.
module sdc_ctrl
   import sdc_pkg::*;
(
   input  wire logic                  sys_clk,
   input  wire logic                  rst,
   input  wire logic                  sdram_clk_feedback,
   input  wire logic                  power_fail_sm_init,
   input  wire logic                  mrs_issue,
   input  wire logic                  bus_req,
   input  wire logic                  bus_write,
   input  wire logic [ADDR_W-1:0]     bus_addr,
   input  wire logic [DATA_W-1:0]     bus_wdata,
   input  wire logic                  mem_rd_valid,
   input  wire logic [DATA_W-1:0]     mem_rd_data,
   input  wire logic [CHK_W-1:0]      mem_rd_check,
   input  wire logic                  int_status_rd,
   input  wire logic [0:0]            ecc_control,
   input  wire logic [CHK_W-1:0]      ecc_test_mask,
   input  wire logic [ADDR_W-1:0]     sdram_region_base,
   input  wire logic [ADDR_W-1:0]     sdram_bank_bound_0,
   input  wire logic [ADDR_W-1:0]     sdram_bank_bound_1,
   input  wire logic [ADDR_W-1:0]     flash_region_base_0,
   input  wire logic [ADDR_W-1:0]     flash_region_base_1,
   input  wire logic [ADDR_W-1:0]     flash_region_size_0,
   input  wire logic [ADDR_W-1:0]     flash_region_size_1,
   output logic [3:0]                 bus_region,
   output logic                       bus_rvalid,
   output logic [DATA_W-1:0]          bus_rdata,
   output logic                       bus_rerr,
   output logic                       mem_wr_en,
   output logic                       mem_rd_req,
   output logic                       mem_bank,
   output logic [ADDR_W-1:0]          mem_addr,
   output logic [DATA_W-1:0]          mem_wr_data,
   output logic [CHK_W-1:0]           mem_wr_check,
   output logic [ST_W-1:0]            mem_ctrl_int_status,
   output logic [ST_W-1:0]            int_status_rdata,
   output logic                       nmi,
   output logic [ADDR_W-1:0]          ecc_error_address_capture_0,
   output logic [ADDR_W-1:0]          ecc_error_address_capture_1,
   output logic [LOG_W-1:0]           ecc_error_log_0,
   output logic [LOG_W-1:0]           ecc_error_log_1,
   output logic [SDCLK_COPIES-1:0]    sdram_clk_out,
   output logic [CMD_W-1:0]           sdram_cmd,
   output logic [CKE_COPIES-1:0]      sdram_clk_enable
);
   typedef enum logic [4:0] {
      PF_IDLE   = 5'b00001,
      PF_QUIET  = 5'b00010,
      PF_PRE    = 5'b00100,
      PF_RFWT   = 5'b01000,
      PF_SREF   = 5'b10000
   } sdc_pf_state_t;

   sdc_link_if          lnk ();
   sdc_pf_state_t       pf_state;
   logic [CNT_W-1:0]    pf_cnt;
   logic                pwr_meta;
   logic                pwr_sync;
   logic                pf_init;
   logic [1:0]          phase_gray;
   logic                cke_req;
   logic [3:0]          rgn;
   logic                rgn_bank;
   logic [ADDR_W-1:0]   rd_addr_q;
   logic [CHK_W-1:0]    syn;
   logic                err_single;
   logic                err_multi;
   logic                err_ev;
   logic                sel0;
   logic                sel1;
   logic [ST_W-1:0]     st_set;
   logic [ST_W-1:0]     next_status;
   logic [LOG_W-1:0]    next_log;

   // hsiao-style column: the i-th byte value of weight three
   function automatic logic [CHK_W-1:0] ecc_col(input int i);
      int          n;
      logic [CHK_W-1:0] c;
      n = 0;
      c = '0;
      for (int v = 0; v < 256; v++) begin
         if ($countones(v[CHK_W-1:0]) == 3) begin
            if (n == i)
               c = v[CHK_W-1:0];
            n++;
         end
      end
      return c;
   endfunction : ecc_col

   function automatic logic [CHK_W-1:0] ecc_gen(input logic [DATA_W-1:0] d);
      logic [CHK_W-1:0] c;
      c = '0;
      for (int i = 0; i < DATA_W; i++) begin
         if (d[i])
            c = c ^ ecc_col(i);
      end
      return c;
   endfunction : ecc_gen

   function automatic logic [DATA_W-1:0] ecc_fix(input logic [DATA_W-1:0] d, input logic [CHK_W-1:0] s);
      logic [DATA_W-1:0] f;
      f = d;
      for (int i = 0; i < DATA_W; i++) begin
         if (s == ecc_col(i))
            f[i] = ~d[i];
      end
      return f;
   endfunction : ecc_fix

   function automatic logic in_range(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base,
                                     input logic [ADDR_W-1:0] size);
      logic [ADDR_W:0] top;
      top = {1'b0, base} + {1'b0, size};
      return (a >= base) && ({1'b0, a} < top);
   endfunction : in_range

   // ---------------- region decode ----------------
   always_comb begin
      rgn_bank = (bus_addr >= sdram_bank_bound_0);
      if (bus_addr >= MMR_LO && bus_addr <= MMR_HI)
         rgn = RGN_MMR; // R10 R13
      else if (in_range(bus_addr, flash_region_base_0, flash_region_size_0))
         rgn = RGN_FLASH0; // R12 R13
      else if (in_range(bus_addr, flash_region_base_1, flash_region_size_1))
         rgn = RGN_FLASH1; // R12 R13
      else if (bus_addr >= sdram_region_base && bus_addr < sdram_bank_bound_1
               && (bus_addr - sdram_region_base) < SDRAM_MAX_BYTES)
         rgn = RGN_SDRAM; // R11 R16
      else
         rgn = RGN_NONE;
   end

   // ---------------- request issue ----------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         bus_region   <= RGN_NONE; // R22
         mem_wr_en    <= 1'b0;
         mem_rd_req   <= 1'b0;
         mem_bank     <= 1'b0;
         mem_addr     <= '0;
         mem_wr_data  <= '0;
         mem_wr_check <= '0;
         rd_addr_q    <= '0;
      end else begin
         mem_wr_en  <= 1'b0;
         mem_rd_req <= 1'b0;
         bus_region <= bus_req ? rgn : RGN_NONE;
         if (bus_req && rgn == RGN_SDRAM) begin
            mem_bank <= rgn_bank;
            mem_addr <= bus_addr;
            if (bus_write) begin
               mem_wr_en    <= 1'b1;
               mem_wr_data  <= bus_wdata;
               mem_wr_check <= ecc_gen(bus_wdata) ^ ecc_test_mask; // R08 R27 R09
            end else begin
               mem_rd_req <= 1'b1;
               rd_addr_q  <= bus_addr;
            end
         end
      end
   end

   // ---------------- read return and ecc check ----------------
   always_comb begin
      syn        = mem_rd_check ^ ecc_gen(mem_rd_data);
      err_single = ^syn;
      err_multi  = (syn != '0) && !err_single;
      // single-bit reports are gated, uncorrectable ones never are
      err_ev     = mem_rd_valid && (err_multi || (err_single && ecc_control[ECC_REPORT_BIT])); // R04 R26
      sel0       = !mem_ctrl_int_status[ST_PAIR0];
      sel1       = mem_ctrl_int_status[ST_PAIR0] && !mem_ctrl_int_status[ST_PAIR1];
      st_set     = {err_ev && sel1, err_ev && sel0};
      // set wins over the read-clear
      next_status = (int_status_rd ? '0 : mem_ctrl_int_status) | st_set; // R03
      next_log   = '0;
      next_log[CHK_W-1:0] = syn;
      next_log[LOG_TYPE_LSB +: 2] = err_multi ? ERR_MULTI : ERR_SINGLE;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         bus_rvalid <= 1'b0;
         bus_rdata  <= '0;
         bus_rerr   <= 1'b0;
      end else begin
         bus_rvalid <= mem_rd_valid;
         if (mem_rd_valid) begin
            bus_rdata <= ecc_fix(mem_rd_data, syn); // R05
            bus_rerr  <= err_multi;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ecc_error_address_capture_0 <= '0;
         ecc_error_address_capture_1 <= '0;
         ecc_error_log_0             <= '0;
         ecc_error_log_1             <= '0;
      end else if (err_ev) begin
         if (sel0) begin
            ecc_error_address_capture_0 <= rd_addr_q; // R01
            ecc_error_log_0             <= next_log; // R01
         end else if (sel1) begin
            ecc_error_address_capture_1 <= rd_addr_q; // R01
            ecc_error_log_1             <= next_log; // R01
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mem_ctrl_int_status <= '0;
         int_status_rdata    <= '0;
         nmi                 <= 1'b0;
      end else begin
         mem_ctrl_int_status <= next_status;
         if (int_status_rd)
            int_status_rdata <= mem_ctrl_int_status; // R03
         nmi <= |(next_status & ~mem_ctrl_int_status); // R02 R23
      end
   end

   // ---------------- sdram clocks ----------------
   // free running even under rst so the power-fail commands still clock out
   genvar g;
   generate
      for (g = 0; g < SDCLK_COPIES; g++) begin : g_clk
         always_ff @(posedge sys_clk) begin
            if (pf_init)
               sdram_clk_out[g] <= 1'b0;
            else
               sdram_clk_out[g] <= ~sdram_clk_out[g]; // R14
         end
      end
   endgenerate

   // ---------------- power-fail machine ----------------
   always_ff @(posedge sys_clk) begin
      pwr_meta <= power_fail_sm_init;
      pwr_sync <= pwr_meta;
   end

   assign pf_init = !pwr_sync; // R24

   always_ff @(posedge sys_clk) begin
      if (pf_init) begin
         pf_state   <= PF_IDLE; // R24
         pf_cnt     <= '0;
         phase_gray <= PH_RUN;
      end else begin
         case (pf_state)
            PF_IDLE: begin
               pf_cnt <= '0;
               if (rst)
                  pf_state <= PF_QUIET; // R19
            end
            PF_QUIET: begin
               pf_cnt <= pf_cnt + 1'b1;
               if (pf_cnt == PF_SETTLE - 1'b1) begin
                  pf_state   <= PF_PRE; // R22
                  pf_cnt     <= '0;
                  phase_gray <= PH_PRE;
               end
            end
            PF_PRE: begin
               pf_cnt <= pf_cnt + 1'b1;
               if (pf_cnt == PF_GAP - 1'b1) begin
                  pf_state   <= PF_RFWT; // R22
                  pf_cnt     <= '0;
                  phase_gray <= PH_AREF;
               end
            end
            PF_RFWT: begin
               pf_cnt <= pf_cnt + 1'b1;
               if (pf_cnt == PF_TRC - 1'b1) begin
                  pf_state   <= PF_SREF; // R22
                  pf_cnt     <= '0;
                  phase_gray <= PH_SREF;
               end
            end
            PF_SREF: begin
               if (!rst) begin
                  pf_state   <= PF_IDLE;
                  phase_gray <= PH_RUN;
               end
            end
            default: begin
               pf_state   <= PF_IDLE;
               pf_cnt     <= '0;
               phase_gray <= PH_RUN;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (pf_init || pf_state == PF_SREF)
         cke_req <= 1'b0; // R17 R25
      else if (mrs_issue)
         cke_req <= 1'b1; // R25
   end

   assign lnk.phase_gray = phase_gray;
   assign lnk.cke_req    = cke_req;
   assign lnk.pf_init    = pf_init;

   sdc_sdram_io u_io (
      .sdram_clk_feedback (sdram_clk_feedback), // R15
      .lnk                (lnk),
      .sdram_cmd          (sdram_cmd),
      .sdram_clk_enable   (sdram_clk_enable)
   );

   // ---------------- checks ----------------
   sequence s_settle;
      pf_state == PF_QUIET [*8];
   endsequence
   sequence s_pre;
      pf_state == PF_PRE [*3];
   endsequence
   sequence s_trc;
      pf_state == PF_RFWT [*8];
   endsequence

   AST_PF_SEQUENCE: assert property (@(posedge sys_clk) disable iff (pf_init) // R22
      (pf_state == PF_IDLE && rst) |=> s_settle ##1 s_pre ##1 s_trc ##1 pf_state == PF_SREF)
      else $error("power-fail sequence timing wrong");
   AST_PF_CKE_LOW: assert property (@(posedge sys_clk) disable iff (pf_init) // R17
      (pf_state == PF_SREF) |=> !cke_req)
      else $error("clock enable request high in self-refresh");
   AST_CAPTURE_ADDR: assert property (@(posedge sys_clk) disable iff (rst) // R01
      (err_ev && sel0) |=> ecc_error_address_capture_0 == $past(rd_addr_q)
                           && mem_ctrl_int_status[ST_PAIR0])
      else $error("error address not captured in pair 0");
   AST_NMI_ON_RISE: assert property (@(posedge sys_clk) disable iff (rst) // R23
      (|(next_status & ~mem_ctrl_int_status)) |=> nmi ##1 !nmi || $rose(nmi) == 1'b0)
      else $error("status rise without interrupt");
   AST_READ_CLEARS: assert property (@(posedge sys_clk) disable iff (rst) // R03
      (int_status_rd && !err_ev) |=> mem_ctrl_int_status == '0
                                     && int_status_rdata == $past(mem_ctrl_int_status))
      else $error("status read did not return and clear");
   AST_MASKED_SINGLE: assert property (@(posedge sys_clk) disable iff (rst) // R26
      (mem_rd_valid && err_single && !ecc_control[ECC_REPORT_BIT] && !int_status_rd)
      |=> $stable(mem_ctrl_int_status) && !nmi)
      else $error("masked single-bit error was reported");
   AST_CORRECTED: assert property (@(posedge sys_clk) disable iff (rst) // R05
      (mem_rd_valid && err_single)
      |=> $countones(ecc_gen(bus_rdata) ^ $past(mem_rd_check)) <= 1)
      else $error("single-bit read not corrected");
   AST_TEST_MASK: assert property (@(posedge sys_clk) disable iff (rst) // R08
      (bus_req && bus_write && rgn == RGN_SDRAM)
      |=> mem_wr_en && mem_wr_check == (ecc_gen($past(bus_wdata)) ^ $past(ecc_test_mask)))
      else $error("write check bits not masked");
   AST_MMR_FIRST: assert property (@(posedge sys_clk) disable iff (rst) // R13
      (bus_req && bus_addr >= MMR_LO && bus_addr <= MMR_HI) |=> bus_region == RGN_MMR)
      else $error("register window lost priority");
endmodule : sdc_ctrl

// File: include/sdc_pkg.sv
// Purpose: shared constants for the sdram controller slice
// Assumes: 32-bit core data, 8 check bits, one outstanding read
// Notes:   region codes are one-hot except the all-zero RGN_NONE, pf phase code is gray
package sdc_pkg;
   localparam int          ADDR_W          = 32;
   localparam int          DATA_W          = 32;
   localparam int          CHK_W           = 8;
   localparam int          SDCLK_COPIES    = 4;
   localparam int          CKE_COPIES      = 2;
   localparam int          CMD_W           = 4;
   localparam int          CNT_W           = 4;

   // fixed register window, inclusive bounds
   localparam logic [31:0] MMR_LO          = 32'h0000_1500;
   localparam logic [31:0] MMR_HI          = 32'h0000_15ff;
   // 512 Mbytes of sdram at most
   localparam logic [31:0] SDRAM_MAX_BYTES = 32'h2000_0000;

   localparam logic [3:0]  RGN_NONE        = 4'h0;
   localparam logic [3:0]  RGN_MMR         = 4'h1;
   localparam logic [3:0]  RGN_FLASH0      = 4'h2;
   localparam logic [3:0]  RGN_FLASH1      = 4'h4;
   localparam logic [3:0]  RGN_SDRAM       = 4'h8;

   localparam int          ECC_REPORT_BIT  = 0;
   localparam int          ST_W            = 2;
   localparam int          ST_PAIR0        = 0;
   localparam int          ST_PAIR1        = 1;
   localparam int          LOG_W           = 10;
   localparam int          LOG_TYPE_LSB    = 8;
   localparam logic [1:0]  ERR_SINGLE      = 2'h1;
   localparam logic [1:0]  ERR_MULTI       = 2'h2;

   // power-fail timing in bus clocks
   localparam logic [3:0]  PF_SETTLE       = 4'h8;
   localparam logic [3:0]  PF_TRC          = 4'h8;
   localparam logic [3:0]  PF_GAP          = 4'h3;

   // {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0]  CMD_NOP         = 4'h7;
   localparam logic [3:0]  CMD_PRE         = 4'h2;
   localparam logic [3:0]  CMD_AREF        = 4'h1;
   localparam logic [3:0]  CMD_SREF        = 4'h1;

   localparam logic [1:0]  PH_RUN          = 2'h0;
   localparam logic [1:0]  PH_PRE          = 2'h1;
   localparam logic [1:0]  PH_AREF         = 2'h3;
   localparam logic [1:0]  PH_SREF         = 2'h2;
endpackage : sdc_pkg

// File: include/sdc_link_if.sv
// Purpose: levels handed from the bus clock side to the sdram clock side
// Assumes: phase_gray and cke_req are flop outputs on the bus clock, pf_init is the inverse of one
// Notes:   phase is gray coded so one bit moves per step
interface sdc_link_if;
   logic [1:0] phase_gray;
   logic       cke_req;
   logic       pf_init;
   modport ctrl (output phase_gray, output cke_req, output pf_init);
   modport io   (input phase_gray, input cke_req, input pf_init);
endinterface : sdc_link_if

// File: hw/sdc_sdram_io.sv
// Purpose: sdram command and clock-enable pins on the feedback clock
// Assumes: bus side holds each phase at least three feedback clocks
// Notes:   reset by the synchronised power-fail init level only
module sdc_sdram_io
   import sdc_pkg::*;
(
   input  wire logic                  sdram_clk_feedback,
   sdc_link_if.io                     lnk,
   output logic [CMD_W-1:0]           sdram_cmd,
   output logic [CKE_COPIES-1:0]      sdram_clk_enable
);
   logic [1:0] ph_meta;
   logic [1:0] ph_sync;
   logic [1:0] ph_prev;
   logic       cke_meta;
   logic       cke_sync;
   logic       ini_meta;
   logic       ini_sync;

   function automatic logic [CMD_W-1:0] phase_cmd(input logic [1:0] ph);
      case (ph)
         PH_PRE:  phase_cmd = CMD_PRE;
         PH_AREF: phase_cmd = CMD_AREF;
         PH_SREF: phase_cmd = CMD_SREF;
         default: phase_cmd = CMD_NOP;
      endcase
   endfunction : phase_cmd

   always_ff @(posedge sdram_clk_feedback) begin
      ph_meta  <= lnk.phase_gray;
      ph_sync  <= ph_meta;
      cke_meta <= lnk.cke_req;
      cke_sync <= cke_meta;
      ini_meta <= lnk.pf_init;
      ini_sync <= ini_meta;
   end

   always_ff @(posedge sdram_clk_feedback) begin
      if (ini_sync) begin
         ph_prev   <= PH_RUN;
         sdram_cmd <= CMD_NOP;
      end else begin
         ph_prev   <= ph_sync;
         // one command per phase step
         sdram_cmd <= (ph_sync != ph_prev) ? phase_cmd(ph_sync) : CMD_NOP; // R22
      end
   end

   always_ff @(posedge sdram_clk_feedback) begin
      if (ini_sync)
         sdram_clk_enable <= '0; // R25
      else
         sdram_clk_enable <= {CKE_COPIES{cke_sync && (ph_sync != PH_SREF)}}; // R17
   end

   AST_SREF_CKE_LOW: assert property (@(posedge sdram_clk_feedback) disable iff (ini_sync) // R17
      (sdram_cmd == CMD_SREF && ph_prev == PH_SREF) |-> sdram_clk_enable == '0)
      else $error("self-refresh issued with clock enable high");
   AST_CMD_ONE_CYCLE: assert property (@(posedge sdram_clk_feedback) disable iff (ini_sync) // R22
      (sdram_cmd != CMD_NOP) |=> (sdram_cmd == CMD_NOP))
      else $error("sdram command held longer than one clock");
endmodule : sdc_sdram_io

// File: bench/sdc_dimm_model.sv
// Purpose: sdram array stand-in answering the controller's memory port
// Assumes: one read outstanding, answered one cycle after the request
// Notes:   flip corrupts data bit 0 of the returned word
module sdc_dimm_model
   import sdc_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              flip,
   input  wire logic              mem_wr_en,
   input  wire logic              mem_rd_req,
   input  wire logic [ADDR_W-1:0] mem_addr,
   input  wire logic [DATA_W-1:0] mem_wr_data,
   input  wire logic [CHK_W-1:0]  mem_wr_check,
   output logic                   mem_rd_valid,
   output logic [DATA_W-1:0]      mem_rd_data,
   output logic [CHK_W-1:0]       mem_rd_check
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [CHK_W+DATA_W-1:0] mem [logic [ADDR_W-1:0]];
   initial begin
      mem_rd_valid = 1'b0;
      {mem_rd_check, mem_rd_data} = '0;
   end
   always @(posedge sys_clk) begin
      if (mem_wr_en === 1'b1)
         mem[mem_addr] = {mem_wr_check, mem_wr_data};
      mem_rd_valid <= (mem_rd_req === 1'b1);
      if (mem_rd_req === 1'b1)
         {mem_rd_check, mem_rd_data} <= mem[mem_addr] ^ {{(CHK_W+DATA_W-1){1'b0}}, flip};
      else
         // idle lines toggle so a stale word is never mistaken for data
         {mem_rd_check, mem_rd_data} <= ~{mem_rd_check, mem_rd_data};
   end
endmodule : sdc_dimm_model

// File: bench/test_sdram_ctrl_ecc_region_powerfail.sv
// Purpose: self-checking bench for the sdram controller slice
// Assumes: bus clock 40 ns, feedback clock 32 ns in free phase
// Notes:   read results are queued by the driver, checked on bus_rvalid
module test_sdram_ctrl_ecc_region_powerfail import sdc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, sdram_clk_feedback, rst, power_fail_sm_init, mrs_issue, flip, nmi;
   logic bus_req, bus_write, mem_rd_valid, int_status_rd, bus_rvalid, bus_rerr, mem_wr_en, mem_rd_req, mem_bank;
   logic [0:0] ecc_control;
   logic [CHK_W-1:0] ecc_test_mask, mem_rd_check, mem_wr_check, c0;
   logic [31:0] bus_addr, mem_addr, sdram_region_base, sdram_bank_bound_0, sdram_bank_bound_1, d;
   logic [31:0] flash_region_base_0, flash_region_base_1, flash_region_size_0, flash_region_size_1;
   logic [31:0] ecc_error_address_capture_0, ecc_error_address_capture_1;
   logic [31:0] bus_wdata, mem_rd_data, bus_rdata, mem_wr_data;
   logic [LOG_W-1:0] ecc_error_log_0, ecc_error_log_1;
   logic [ST_W-1:0] mem_ctrl_int_status, int_status_rdata;
   logic [3:0] bus_region, sdram_clk_out, sdram_cmd, c;
   logic [1:0] sdram_clk_enable;
   logic [15:0] lf;
   logic [32:0] e;
   logic [32:0] exp_q[$];
   logic [5:0] cmd_q[$];
   int err_count, checks_done, nmis, i;
   localparam logic [31:0] RA [8] = '{32'h14ff, 32'h1500, 32'h15ff, 32'h1600, 32'h1800, 32'h2000, 32'h2800,
                                      32'h1000_0000};
   localparam logic [3:0] RR [8] = '{RGN_FLASH0, RGN_MMR, RGN_MMR, RGN_FLASH0, RGN_FLASH0, RGN_FLASH1, RGN_SDRAM,
                                     RGN_NONE};
   sdc_ctrl u_dut (.*);
   sdc_dimm_model u_mem (.*);
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   initial begin
      sdram_clk_feedback = 1'b0;
      #7;
      forever #16 sdram_clk_feedback = ~sdram_clk_feedback;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic results;
      $display("errors %0d checks %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : results
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : cyc
   task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] v, input logic [3:0] rgn);
      bus_req <= 1'b1;
      bus_write <= w;
      bus_addr <= a;
      bus_wdata <= v;
      cyc(1);
      bus_req <= 1'b0;
      cyc(1);
      chk(bus_region, rgn);
   endtask : acc
   task automatic rd(input logic [31:0] a, input logic [32:0] x);
      exp_q.push_back(x);
      acc(1'b0, a, '0, RGN_SDRAM);
      for (i = 0; i < 20 && exp_q.size() > 0; i++)
         cyc(1);
      if (exp_q.size() > 0) begin
         chk(1, 0);
         results();
      end
   endtask : rd
   task automatic mrs_chk;
      mrs_issue <= 1'b1;
      cyc(1);
      mrs_issue <= 1'b0;
      cyc(8);
      chk(sdram_clk_enable, 2'b11);
   endtask : mrs_chk
   // result watcher: oldest note against each read answer
   always @(posedge sys_clk) begin
      if (bus_rvalid === 1'b1) begin
         e = exp_q.pop_front();
         chk({bus_rerr, e[32] ? e[31:0] : bus_rdata}, e);
      end
      if (nmi === 1'b1)
         nmis++;
   end
   always @(posedge sdram_clk_feedback)
      if (sdram_cmd !== CMD_NOP)
         cmd_q.push_back({sdram_clk_enable, sdram_cmd});
   initial begin
      lf = 16'heb12;
      {rst, power_fail_sm_init, mrs_issue, flip, bus_req, bus_write, int_status_rd} = 7'b1000000;
      {bus_addr, bus_wdata, ecc_test_mask, ecc_control} = {64'h0, 8'h00, 1'b1};
      {sdram_region_base, sdram_bank_bound_0, sdram_bank_bound_1} = {32'h0, 32'h0800_0000, 32'h1000_0000};
      {flash_region_base_0, flash_region_size_0} = {32'h1000, 32'h1000};
      {flash_region_base_1, flash_region_size_1} = {32'h1800, 32'h1000};
      cyc(16);
      power_fail_sm_init <= 1'b1;
      cyc(1);
      rst <= 1'b0;
      cyc(6);
      chk(sdram_clk_enable, 2'b00);
      mrs_chk();
      c = sdram_clk_out;
      cyc(1);
      chk(sdram_clk_out, {4{~c[0]}});
      for (int k = 0; k < 8; k++)
         acc(1'b1, RA[k], '0, RR[k]);
      for (int k = 0; k < 4; k++) begin
         lf = lfsr(lf);
         acc(1'b1, {8'h01, lf, 8'h00}, {lf, ~lf}, RGN_SDRAM);
         chk(mem_bank, 1'b0);
      end
      d = {lf, lf ^ 16'h3c5a};
      acc(1'b1, 32'h0900_0000, d, RGN_SDRAM);
      chk(mem_bank, 1'b1);
      c0 = mem_wr_check;
      ecc_test_mask <= 8'h5a;
      acc(1'b1, 32'h0900_0000, d, RGN_SDRAM);
      chk(mem_wr_check, c0 ^ 8'h5a);
      ecc_test_mask <= 8'h00;
      acc(1'b1, 32'h0900_0000, d, RGN_SDRAM);
      chk({mem_wr_data, mem_wr_check}, {d, c0});
      flip <= 1'b1;
      rd(32'h0900_0000, {1'b0, d});
      chk(ecc_error_address_capture_0, 32'h0900_0000);
      chk({ecc_error_log_0[9:8], mem_ctrl_int_status, nmis}, {ERR_SINGLE, 2'b01, 32'd1});
      int_status_rd <= 1'b1;
      cyc(1);
      int_status_rd <= 1'b0;
      cyc(1);
      chk({int_status_rdata, mem_ctrl_int_status}, 4'b0100);
      ecc_control <= 1'b0;
      rd(32'h0900_0000, {1'b0, d});
      chk({mem_ctrl_int_status, nmis}, {2'b00, 32'd1});
      acc(1'b1, 32'h0900_0000, d, RGN_SDRAM);
      {ecc_control, flip, ecc_test_mask} <= {1'b1, 1'b0, 8'h03};
      rd(32'h0900_0000, {1'b0, d});
      acc(1'b1, 32'h4000, d, RGN_SDRAM);
      ecc_test_mask <= 8'h01;
      acc(1'b1, 32'h8000, ~d, RGN_SDRAM);
      ecc_test_mask <= 8'h00;
      rd(32'h4000, {1'b1, d});
      rd(32'h8000, {1'b0, ~d});
      chk({ecc_error_log_0, ecc_error_log_1}, {ERR_MULTI, 8'h03, ERR_SINGLE, 8'h01});
      chk(ecc_error_address_capture_1, 32'h8000);
      chk({mem_ctrl_int_status, nmis}, {2'b11, 32'd3});
      cmd_q.delete();
      rst <= 1'b1;
      cyc(40);
      chk(cmd_q.size(), 3);
      chk({cmd_q[0], cmd_q[1], cmd_q[2]}, {2'b11, CMD_PRE, 2'b11, CMD_AREF, 2'b00, CMD_SREF});
      chk(sdram_clk_enable, 2'b00);
      rst <= 1'b0;
      cyc(6);
      chk(sdram_clk_enable, 2'b00);
      mrs_chk();
      results();
   end
endmodule : test_sdram_ctrl_ecc_region_powerfail
